// ==== bench/bus_ctrl_model.sv ====
// Behavioural bus controller facing the port
`timescale 1ns/1ps
module bus_ctrl_model
(
   // Clock
   input wire logic mclk,
   // Wire levels
   input wire logic nrfd_w,
   input wire logic ndac_w,
   input wire logic dav_w,
   input wire logic [7:0] dio_w,
   // Controller drive
   output logic [7:0] dio,
   output logic dav,
   output logic atn,
   output logic nrfd,
   output logic ndac
);
   initial
   begin
      dio = 8'hff;
      dav = 1'b0;
      atn = 1'b0;
      nrfd = 1'b0;
      ndac = 1'b1;
   end
   // Source side; refusal shows as ok low with dav never raised
   task automatic send(input logic [7:0] v, input logic a, output logic ok);
      int i;
      ok = 1'b0;
      ndac = 1'b0;
      atn = a;
      // Let the port's synchronised ready show before trusting nrfd
      repeat (4) @(negedge mclk);
      for (i = 0; i < 60 && nrfd_w !== 1'b0; i++) @(negedge mclk);
      if (nrfd_w === 1'b0)
      begin
         dio = v;
         @(negedge mclk);
         dav = 1'b1;
         for (i = 0; i < 60 && ndac_w !== 1'b0; i++) @(negedge mclk);
         ok = (ndac_w === 1'b0);
         dav = 1'b0;
         dio = ~v;
      end
      @(negedge mclk);
      atn = 1'b0;
      ndac = 1'b1;
   endtask : send
   // Acceptor side while the port talks
   task automatic recv(output logic [7:0] v, output logic ok);
      int i;
      ok = 1'b0;
      for (i = 0; i < 80 && dav_w !== 1'b1; i++) @(negedge mclk);
      v = dio_w;
      nrfd = 1'b1;
      ndac = 1'b0;
      for (i = 0; i < 80 && dav_w !== 1'b0; i++) @(negedge mclk);
      ok = (dav_w === 1'b0) && (v !== 8'hxx);
      ndac = 1'b1;
      nrfd = 1'b0;
   endtask : recv
endmodule : bus_ctrl_model

// ==== bench/bus_port_properties.sv ====
// Concurrent checks on the ports of the instrument-bus port
`timescale 1ns/1ps
`include "bus_port_cfg.svh"
module bus_port_properties
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Bus side
   input wire logic ren_in,
   input wire logic atn_in,
   input wire logic nrfd_in,
   input wire logic srq_in,
   input wire logic dav_out,
   input wire logic dav_oe,
   input wire logic dio_oe,
   input wire logic ren_oe,
   // Panel and control
   input wire logic sys_ctrl,
   input wire logic local_key,
   input wire logic srq_seen,
   input wire logic keys_enabled,
   input wire logic remote_ind,
   input wire logic listen_ind,
   input wire logic talk_ind,
   input wire logic lockout,
   input wire logic [`TRIG_W-1:0] trigger_setup,
   input wire logic dev_clear,
   input wire logic rx_valid
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////////////
   property p_keys;
      (remote_ind || lockout) [*2] |-> !keys_enabled;
   endproperty
   a_keys: assert property (p_keys) else $error("keys live");
   property p_ren_low;
      (!ren_in) [*5] |-> !remote_ind;
   endproperty
   a_ren_low: assert property (p_ren_low) else $error("remote");
   property p_lock_clr;
      (!ren_in) [*5] |-> !lockout;
   endproperty
   a_lock_clr: assert property (p_lock_clr) else $error("lockout");
   property p_rem_lsn;
      $rose(remote_ind) |-> listen_ind;
   endproperty
   a_rem_lsn: assert property (p_rem_lsn) else $error("unaddressed");
   property p_loc_trig;
      $fell(remote_ind) |-> ##[0:2] trigger_setup == `DEFAULT_TRIG;
   endproperty
   a_loc_trig: assert property (p_loc_trig) else $error("trigger");
   property p_lock_key;
      lockout && remote_ind && local_key && ren_in && !atn_in |=> remote_ind;
   endproperty
   a_lock_key: assert property (p_lock_key) else $error("key left");
   property p_srq;
      (sys_ctrl && srq_in) [*4] |-> srq_seen;
   endproperty
   a_srq: assert property (p_srq) else $error("srq missed");
   property p_ren_drv;
      (!sys_ctrl) [*2] |-> !ren_oe;
   endproperty
   a_ren_drv: assert property (p_ren_drv) else $error("ren driven");
   property p_dav;
      nrfd_in [*4] |=> !$rose(dav_out && dav_oe);
   endproperty
   a_dav: assert property (p_dav) else $error("dav early");
   property p_talk;
      $rose(dio_oe) |-> talk_ind;
   endproperty
   a_talk: assert property (p_talk) else $error("talk unaddr");
   property p_clear;
      dev_clear |=> !dev_clear ##[0:2] !rx_valid;
   endproperty
   a_clear: assert property (p_clear) else $error("clear");
endmodule : bus_port_properties

// ==== bench/bus_port_tb_top.sv ====
// Self-checking bench of the instrument-bus port
`timescale 1ns/1ps
module bus_port_tb_top;
   logic mclk = 0, rst = 1, ren = 0, sys_ctrl = 0, assert_ren = 0, srq = 0;
   logic local_key = 0, trig_set = 0, rx_ready = 0, tx_valid = 0, ok;
   logic [4:0] addr = 5'h0d;
   logic [3:0] trig_cfg = 4'h0, trigger_setup;
   logic [7:0] v, dio_out, m_dio;
   logic dio_oe, dav_out, dav_oe, nrfd_out, nrfd_oe, ndac_out, ndac_oe;
   logic eoi_out, eoi_oe, ren_out, ren_oe, m_dav, m_atn, m_nrfd, m_ndac;
   logic srq_seen, keys_enabled, remote_ind, listen_ind, talk_ind, lockout;
   logic dev_clear, rx_valid, tx_ready, dev_trigger, take_control;
   logic eoi_seen = 0;
   logic dav_w, nrfd_w, ndac_w;
   logic [7:0] dio_w;
   bus_port_pkg::bus_byte_t tx_byte = '0, rx_byte;
   int num_errors = 0, n_compared = 0, clr_cnt = 0, i;
   int trg_cnt = 0, tc_cnt = 0;
   assign dav_w = m_dav | (dav_oe & dav_out);
   assign nrfd_w = m_nrfd | (nrfd_oe & nrfd_out);
   assign ndac_w = m_ndac | (ndac_oe & ndac_out);
   assign dio_w = dio_oe ? dio_out : m_dio;
   always #20 mclk = ~mclk;
   always @(posedge mclk) if (dev_clear === 1'b1) clr_cnt++;
   always @(posedge mclk) if (dev_trigger === 1'b1) trg_cnt++;
   always @(posedge mclk) if (take_control === 1'b1) tc_cnt++;
   always @(negedge mclk)
      if (dav_w === 1'b1 && dio_oe === 1'b1) eoi_seen = eoi_oe & eoi_out;
   ////////////////////////////////////////////////////////////////////////
   bus_port uut (.mclk, .rst, .dio_in(dio_w), .dio_out, .dio_oe,
      .dav_in(dav_w), .dav_out, .dav_oe, .nrfd_in(nrfd_w), .nrfd_out,
      .nrfd_oe, .ndac_in(ndac_w), .ndac_out, .ndac_oe,
      .eoi_in(eoi_oe & eoi_out), .eoi_out, .eoi_oe, .atn_in(m_atn),
      .ifc_in(1'b0), .ren_in(ren | (ren_oe & ren_out)), .srq_in(srq),
      .ren_out, .ren_oe, .sys_ctrl, .assert_ren, .srq_seen,
      .take_control, .bus_address_field(addr), .local_key,
      .keys_enabled, .remote_ind, .listen_ind, .talk_ind, .lockout,
      .trig_set, .trig_cfg, .trigger_setup, .dev_trigger, .dev_clear,
      .rx_valid, .rx_ready, .rx_byte, .tx_valid, .tx_ready, .tx_byte);
   bus_ctrl_model m (.mclk, .nrfd_w, .ndac_w, .dav_w, .dio_w, .dio(m_dio),
      .dav(m_dav), .atn(m_atn), .nrfd(m_nrfd), .ndac(m_ndac));
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [7:0] e,
      input logic [7:0] g);
      n_compared++;
      if (g !== e)
      begin
         $display("[ERR] %s expected %h seen %h", nm, e, g);
         num_errors++;
      end
   endtask : chk
   task automatic cmd(input logic [7:0] c);
      m.send(c, 1'b1, ok);
      chk("cmd ack", 8'h01, {7'h00, ok});
      repeat (4) @(negedge mclk);
   endtask : cmd
   task automatic wrap_up;
      if (num_errors == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : wrap_up
   initial
   begin
      repeat (5) @(negedge mclk);
      rst = 1'b0;
      repeat (4) @(negedge mclk);
      chk("state", 8'h08, {remote_ind, listen_ind, talk_ind, lockout,
         keys_enabled, trigger_setup[2:0]});
      ren = 1'b1;
      cmd(8'h2e);
      chk("other addr", 8'h00, {7'h00, listen_ind});
      addr = 5'h1f;
      cmd(8'h2e);
      chk("listen", 8'h60, {1'b0, remote_ind, listen_ind, keys_enabled,
         trigger_setup});
      trig_cfg = 4'h5;
      trig_set = 1'b1;
      @(negedge mclk);
      trig_set = 1'b0;
      for (i = 0; i < 16; i++)
      begin
         m.send(8'h40 + i[7:0], 1'b0, ok);
         chk("rx ack", 8'h01, {7'h00, ok});
      end
      m.send(8'haa, 1'b0, ok);
      chk("refused", 8'h00, {7'h00, ok});
      for (i = 0; i < 16; i++)
      begin
         chk("rx", 8'h40 + i[7:0], rx_valid ? rx_byte.data : 8'hee);
         rx_ready = 1'b1;
         @(negedge mclk);
         rx_ready = 1'b0;
      end
      chk("empty", 8'h00, {7'h00, rx_valid});
      local_key = 1'b1;
      repeat (6) @(negedge mclk);
      local_key = 1'b0;
      chk("key local", 8'h00, {3'h0, remote_ind, trigger_setup});
      cmd(8'h3f);
      cmd(8'h2e);
      chk("remote trig", 8'h15, {3'h0, remote_ind, trigger_setup});
      cmd(8'h08);
      chk("trigger", 8'h01, trg_cnt[7:0]);
      cmd(8'h01);
      chk("gtl", 8'h00, {7'h00, remote_ind});
      cmd(8'h2e);
      cmd(8'h11);
      cmd(8'h15);
      cmd(8'h6e);
      local_key = 1'b1;
      repeat (6) @(negedge mclk);
      local_key = 1'b0;
      chk("locked", 8'h07, {5'h00, remote_ind, lockout, listen_ind});
      m.send(8'h77, 1'b0, ok);
      chk("rx one", 8'h03, {6'h00, ok, rx_valid});
      cmd(8'h14);
      chk("clear", 8'h02, {clr_cnt[6:0], rx_valid});
      ren = 1'b0;
      repeat (6) @(negedge mclk);
      chk("ren low", 8'h01, {6'h00, remote_ind | lockout, keys_enabled});
      cmd(8'h4e);
      chk("talk", 8'h01, {7'h00, talk_ind});
      tx_byte = '{data: 8'h3c, eoi: 1'b1};
      tx_valid = 1'b1;
      for (i = 0; i < 50 && tx_ready !== 1'b1; i++) @(negedge mclk);
      chk("tx ready", 8'h01, {7'h00, tx_ready});
      @(negedge mclk);
      tx_valid = 1'b0;
      m.recv(v, ok);
      chk("tx", 8'h3c, ok ? v : 8'hee);
      chk("eoi", 8'h01, {7'h00, eoi_seen});
      cmd(8'h09);
      chk("take ctrl", 8'h01, tc_cnt[7:0]);
      sys_ctrl = 1'b1;
      assert_ren = 1'b1;
      srq = 1'b1;
      repeat (6) @(negedge mclk);
      chk("ctrl", 8'h03, {6'h00, srq_seen, ren_oe & ren_out});
      wrap_up();
   end
endmodule : bus_port_tb_top
bind bus_port bus_port_properties u_chk (.mclk, .rst, .ren_in, .atn_in,
   .nrfd_in, .srq_in, .dav_out, .dav_oe, .dio_oe, .ren_oe, .sys_ctrl,
   .local_key, .srq_seen, .keys_enabled, .remote_ind, .listen_ind,
   .talk_ind, .lockout, .trigger_setup, .dev_clear, .rx_valid);

// ==== design/bus_port.sv ====
// Instrument-bus listener, talker, handshakes and remote/local control
`timescale 1ns/1ps
`include "bus_port_cfg.svh"

module byte_fifo #(parameter int WIDTH = 9, parameter int DEPTH = 16,
   parameter int AW = 4)
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   input wire logic flush,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   logic push;
   logic pop;
   assign in_ready = (count != (AW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign out_data = mem[rd_ptr];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   always_ff @(posedge mclk)
   begin
      if (push)
         mem[wr_ptr] <= in_data;
   end
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end
      else if (flush)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end
      else
      begin
         if (push)
            wr_ptr <= wr_ptr + 1'b1;
         if (pop)
            rd_ptr <= rd_ptr + 1'b1;
         if (push && !pop)
            count <= count + 1'b1;
         else if (pop && !push)
            count <= count - 1'b1;
      end
   end
endmodule : byte_fifo

////////////////////////////////////////////////////////////////////////////

module bus_port
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Bus data lines and handshake, active high at this boundary
   input wire logic [7:0] dio_in,
   output logic [7:0] dio_out,
   output logic dio_oe,
   input wire logic dav_in,
   output logic dav_out,
   output logic dav_oe,
   input wire logic nrfd_in,
   output logic nrfd_out,
   output logic nrfd_oe,
   input wire logic ndac_in,
   output logic ndac_out,
   output logic ndac_oe,
   input wire logic eoi_in,
   output logic eoi_out,
   output logic eoi_oe,
   // Bus management lines
   input wire logic atn_in,
   input wire logic ifc_in,
   input wire logic ren_in,
   input wire logic srq_in,
   output logic ren_out,
   output logic ren_oe,
   // Controller role
   input wire logic sys_ctrl,
   input wire logic assert_ren,
   output logic srq_seen,
   output logic take_control,
   // Stored address from non-volatile storage
   input wire logic [4:0] bus_address_field,
   // Front panel
   input wire logic local_key,
   output logic keys_enabled,
   output logic remote_ind,
   output logic listen_ind,
   output logic talk_ind,
   output logic lockout,
   // Trigger configuration
   input wire logic trig_set,
   input wire logic [`TRIG_W-1:0] trig_cfg,
   output logic [`TRIG_W-1:0] trigger_setup,
   output logic dev_trigger,
   output logic dev_clear,
   // Received data to the parser
   output logic rx_valid,
   input wire logic rx_ready,
   output bus_port_pkg::bus_byte_t rx_byte,
   // Results to send
   input wire logic tx_valid,
   output logic tx_ready,
   input wire bus_port_pkg::bus_byte_t tx_byte
);
   logic [7:0] dio_m, dio_s;
   logic [8:0] ctl_m, ctl_s;
   logic atn, ifc, ren, srq, dav, nrfd, ndac, eoi, panel_key;
   logic [4:0] my_addr;
   logic remote, lad, tad, ah_done, mla_rx, enter_rem;
   logic [`TRIG_W-1:0] remote_trig;
   logic remote_trig_set;
   bus_port_pkg::acc_state_t ah;
   bus_port_pkg::src_state_t sh;
   logic [7:0] cmd;
   logic fifo_ready, fifo_in;
   logic tx_pend;
   bus_port_pkg::bus_byte_t tx_hold;

   ////////////////////////////////////////////////////////////////////////
   // Two-flop synchronisers on every pin input
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         dio_m <= 8'h00;
         dio_s <= 8'h00;
         ctl_m <= 9'h000;
         ctl_s <= 9'h000;
      end
      else
      begin
         dio_m <= dio_in;
         dio_s <= dio_m;
         ctl_m <= {atn_in, ifc_in, ren_in, srq_in, dav_in, nrfd_in,
            ndac_in, eoi_in, local_key};
         ctl_s <= ctl_m;
      end
   end
   assign {atn, ifc, ren, srq, dav, nrfd, ndac, eoi, panel_key} = ctl_s;
   assign cmd = dio_s;

   // Out-of-range stored addresses fall back to the factory value
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         my_addr <= `FACTORY_ADDR; // R9
      else if (bus_address_field <= `MAX_ADDR) // R10 R11
         my_addr <= bus_address_field;
      else
         my_addr <= `FACTORY_ADDR;
   end

   ////////////////////////////////////////////////////////////////////////
   // Acceptor handshake: command bytes always, data only when listening
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         ah <= bus_port_pkg::ah_idle;
      else
         case (ah)
            bus_port_pkg::ah_idle:
               if ((atn || (lad && fifo_ready)) && !dav) // R5
                  ah <= bus_port_pkg::ah_ready;
            bus_port_pkg::ah_ready:
               if (dav && !(atn || lad))
                  ah <= bus_port_pkg::ah_idle;
               else if (dav)
                  ah <= bus_port_pkg::ah_accept;
            bus_port_pkg::ah_accept:
               if (!dav) // R5
                  ah <= bus_port_pkg::ah_idle;
            default:
               ah <= bus_port_pkg::ah_idle;
         endcase
   end
   assign ah_done = (ah == bus_port_pkg::ah_ready) && dav && (atn || lad);
   assign fifo_in = ah_done && !atn && lad;
   // Remote starts on the listen address itself, not on the addressed
   // level, so a local request holds until the controller re-addresses
   assign mla_rx = ah_done && atn && cmd[6:5] == `LAG_BASE
      && cmd[4:0] == my_addr;
   assign enter_rem = ren && mla_rx && !remote && !(panel_key && !lockout);

   // Addressing and universal commands, decoded once per accepted byte
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         lad <= 1'b0; // R25
         tad <= 1'b0;
         lockout <= 1'b0;
         dev_trigger <= 1'b0;
         dev_clear <= 1'b0;
         take_control <= 1'b0;
      end
      else
      begin
         dev_trigger <= 1'b0;
         dev_clear <= 1'b0;
         take_control <= 1'b0;
         if (ifc)
         begin
            lad <= 1'b0;
            tad <= 1'b0;
         end
         else if (ah_done && atn)
         begin
            // Secondary bytes and parallel poll codes fall through
            if (cmd[6:0] == `CMD_UNL) // R3 R6
               lad <= 1'b0;
            else if (cmd[6:0] == `CMD_UNT)
               tad <= 1'b0;
            else if (cmd[6:5] == `LAG_BASE && cmd[4:0] == my_addr) // R2 R4
               lad <= 1'b1;
            else if (cmd[6:5] == `TAG_BASE) // R1 R4
               tad <= (cmd[4:0] == my_addr);
            if (cmd[6:0] == `CMD_LLO)
               lockout <= 1'b1; // R19
            if (cmd[6:0] == `CMD_DCL || (lad && cmd[6:0] == `CMD_SDC))
               dev_clear <= 1'b1; // R24
            if (lad && remote && cmd[6:0] == `CMD_GET)
               dev_trigger <= 1'b1;
            if (tad && cmd[6:0] == `CMD_TCT)
               take_control <= 1'b1; // R7
         end
         if (!ren)
            lockout <= 1'b0; // R21
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Remote/local state machine and trigger configuration
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         remote <= 1'b0; // R25
      end
      else
      begin
         if (!ren)
            remote <= 1'b0; // R16 R21
         else if (ah_done && atn && lad && cmd[6:0] == `CMD_GTL)
            remote <= 1'b0; // R16
         else if (panel_key && !lockout)
            remote <= 1'b0; // R16 R18
         else if (enter_rem)
            remote <= 1'b1; // R12
      end
   end

   // Settings made in remote are remembered for the next remote entry
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         remote_trig <= `DEFAULT_TRIG; // R23
         remote_trig_set <= 1'b0;
         trigger_setup <= `DEFAULT_TRIG;
      end
      else
      begin
         if (trig_set && remote)
         begin
            remote_trig <= trig_cfg;
            remote_trig_set <= 1'b1;
            trigger_setup <= trig_cfg;
         end
         else if (enter_rem)
            trigger_setup <= remote_trig_set ? remote_trig
               : `DEFAULT_TRIG; // R15 R23
         else if (!remote)
            trigger_setup <= `DEFAULT_TRIG; // R17
      end
   end

   // Panel indicators; remote keeps local key, power and knobs active
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         remote_ind <= 1'b0;
         keys_enabled <= 1'b1;
         listen_ind <= 1'b0;
         talk_ind <= 1'b0;
      end
      else
      begin
         remote_ind <= remote; // R14
         keys_enabled <= !remote && !lockout; // R13 R19
         listen_ind <= lad;
         talk_ind <= tad;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Receive FIFO; its fullness holds off the acceptor handshake for data bytes, not commands
   byte_fifo #(.WIDTH(9), .DEPTH(`FIFO_DEPTH), .AW(`FIFO_AW)) rx_fifo
   (
      .mclk(mclk),
      .rst(rst),
      .flush(dev_clear), // R24
      .in_valid(fifo_in),
      .in_ready(fifo_ready),
      .in_data({dio_s, eoi}), // R8
      .out_valid(rx_valid),
      .out_ready(rx_ready),
      .out_data(rx_byte)
   );

   ////////////////////////////////////////////////////////////////////////
   // Source handshake for talker data; results and errors go out here
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         sh <= bus_port_pkg::sh_idle;
         tx_pend <= 1'b0;
         tx_hold <= '0;
         dav_out <= 1'b0;
         dio_out <= 8'h00;
         eoi_out <= 1'b0;
      end
      else if (dev_clear || ifc || !tad || atn)
      begin
         // Clearing drops any byte queued for output
         sh <= bus_port_pkg::sh_idle;
         tx_pend <= dev_clear ? 1'b0 : tx_pend; // R24
         dav_out <= 1'b0;
         if (tx_valid && !tx_pend && !dev_clear)
         begin
            tx_pend <= 1'b1;
            tx_hold <= tx_byte;
         end
      end
      else
         case (sh)
            bus_port_pkg::sh_idle:
               if (tx_pend || tx_valid) // R22
               begin
                  if (!tx_pend)
                     tx_hold <= tx_byte;
                  tx_pend <= 1'b1;
                  sh <= bus_port_pkg::sh_setup;
               end
            bus_port_pkg::sh_setup:
            begin
               dio_out <= tx_hold.data;
               eoi_out <= tx_hold.eoi;
               if (!nrfd) // R5
                  sh <= bus_port_pkg::sh_valid;
            end
            bus_port_pkg::sh_valid:
            begin
               dav_out <= 1'b1;
               if (!ndac) // R5
               begin
                  sh <= bus_port_pkg::sh_wait;
                  tx_pend <= 1'b0;
               end
            end
            bus_port_pkg::sh_wait:
            begin
               dav_out <= 1'b0;
               sh <= bus_port_pkg::sh_idle;
            end
            default:
               sh <= bus_port_pkg::sh_idle;
         endcase
   end
   assign tx_ready = !tx_pend && (sh == bus_port_pkg::sh_idle);

   // Pin enables and controller lines, all registered
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         dio_oe <= 1'b0;
         dav_oe <= 1'b0;
         eoi_oe <= 1'b0;
         nrfd_out <= 1'b0;
         nrfd_oe <= 1'b0;
         ndac_out <= 1'b0;
         ndac_oe <= 1'b0;
         ren_out <= 1'b0;
         ren_oe <= 1'b0;
         srq_seen <= 1'b0;
      end
      else
      begin
         dio_oe <= tad && !atn && sh != bus_port_pkg::sh_idle; // R1
         dav_oe <= tad && !atn;
         eoi_oe <= tad && !atn && sh != bus_port_pkg::sh_idle;
         nrfd_out <= (atn || lad) && ah != bus_port_pkg::ah_ready; // R5
         nrfd_oe <= atn || lad;
         ndac_out <= (atn || lad) && ah != bus_port_pkg::ah_accept;
         ndac_oe <= atn || lad;
         ren_out <= sys_ctrl && assert_ren; // R7
         ren_oe <= sys_ctrl;
         srq_seen <= sys_ctrl && srq; // R7
      end
   end
endmodule : bus_port

// ==== pkg/bus_port_cfg.svh ====
// Constants of the instrument-bus port
// Function
// R1: Talk only when addressed, no talk-only
// R2: Listen only when addressed, no listen-only
// R3: No secondary addressing; secondaries ignored
// R4: Exactly one primary address recognised
// R5: Full source and acceptor three-wire handshakes
// R6: Parallel poll commands ignored entirely
// R7: System controller may assert remote enable
// R8: Common-command conventions, own operation-complete
// R9: Factory bus address is decimal 14
// R10: Accept bus addresses 0 to 30 only
// R11: Bus address kept in non-volatile storage
// R12: Remote needs enable asserted and listen-addressed
// R13: Remote blocks keys except local, power, knobs
// R14: Remote indicator lit while in remote
// R15: Entering remote restores last remote trigger
// R16: Local on go-to-local, local key, enable low
// R17: Returning local forces default trigger setup
// R18: Lockout makes local key ineffective
// R19: Lockout command disables all front keys
// R20: Only controller or power cycle ends lockout
// R21: Enable low clears lockout, enters local
// R22: Results and errors readable over bus
// R23: No remote trigger yet means default setup
// R24: Device clear empties queues, keeps settings
// R25: Power-up local, unlocked, unaddressed
`ifndef BUS_PORT_CFG_SVH
`define BUS_PORT_CFG_SVH
`define FACTORY_ADDR 5'h0e
`define MAX_ADDR 5'h1e
`define TRIG_W 4
`define DEFAULT_TRIG 4'h0
`define CMD_GTL 7'h01
`define CMD_SDC 7'h04
`define CMD_PPC 7'h05
`define CMD_GET 7'h08
`define CMD_TCT 7'h09
`define CMD_LLO 7'h11
`define CMD_DCL 7'h14
`define CMD_PPU 7'h15
`define CMD_SPE 7'h18
`define CMD_SPD 7'h19
`define CMD_UNL 7'h3f
`define CMD_UNT 7'h5f
`define LAG_BASE 2'b01
`define TAG_BASE 2'b10
`define SCG_BASE 2'b11
`define FIFO_DEPTH 16
`define FIFO_AW 4
`endif

// ==== pkg/bus_port_pkg.sv ====
// Types of the instrument-bus port
package bus_port_pkg;
   typedef struct packed
   {
      logic [7:0] data;
      logic eoi;
   } bus_byte_t;
   typedef enum logic [2:0]
   {
      ah_idle = 3'b001,
      ah_ready = 3'b010,
      ah_accept = 3'b100
   } acc_state_t;
   typedef enum logic [3:0]
   {
      sh_idle = 4'b0001,
      sh_setup = 4'b0010,
      sh_valid = 4'b0100,
      sh_wait = 4'b1000
   } src_state_t;
endpackage : bus_port_pkg
